// File: rtl/isr_cfg.svh
// Constants for the serial register slave
//
// Function
// R1 - I2C read: write register address, repeated start, read address, then data
// R2 - Master acks bytes it wants, withholds ack on last, then Stop
// R3 - Auto-increment range: counter steps after each output byte, wraps to zero
// R4 - Non-increment range: counter fixed, every byte from same register
// R5 - Ninth bit high after read byte: stop sending, return to idle
// R6 - I2C write: register address then data bytes, each acknowledged, Stop ends
// R7 - Multi-byte I2C write steps counter only in auto-increment ranges, wraps
// R8 - SPI transfer starts on chip select fall; first bit 1 read, 0 write
// R9 - Seven address bits follow the read/write bit, most significant first
// R10 - SPI read data leaves MSB first from launch after last address bit
// R11 - Full duplex reads: next byte ignored with auto-increment, else next address
// R12 - Master ends SPI read with an all-zero address byte
// R13 - SPI write bytes after address are data; address steps if auto-increment
// R14 - Chip select high before final launch aborts; final launch completes
// R15 - Glitches up to 50 ns on chip select and serial clock are rejected
// R16 - Strap pins give inverted clock polarity and clock phase at reset
// R17 - New written mode applies from the next chip select assertion
// R18 - Auto-increment for SPI reads and writes, daisy chain for writes
// R19 - Address select pin picks device address; ack only on a match
// R20 - Slave-out released whenever chip select is high
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

`define ISR_I2C_DEV0   8'h82
`define ISR_I2C_DEV1   8'h88
`define ISR_GLITCH_NS  50
`define ISR_LINK_NS    160
`define ISR_BYTE_BITS  4'h8
`define ISR_ADDR_RST   8'h00
`define ISR_MODE_RST   2'h0
`define ISR_STRAP_DLY  2'h3
`define ISR_LAST_ADDR  8'h7f
`define ISR_NOINC_LO   8'h7f
`define ISR_NOINC_HI   8'h7f

`endif

// File: rtl/isr_pkg.sv
// Types shared by the serial register slave
package isr_pkg;

  typedef logic [1:0] isr_mode_t;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_DEV, I2C_DACK, I2C_REG, I2C_ACK, I2C_WR, I2C_RD, I2C_MACK
  } isr_i2c_e;

  typedef enum logic [2:0] {
    SPI_IDLE, SPI_CMD, SPI_RD, SPI_WR, SPI_END
  } isr_spi_e;

  // Register access toward the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } isr_reg_s;

  // Request carried across the clock domains
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } isr_req_s;

endpackage

// File: rtl/isr_slave.sv
// I2C / SPI register slave with link-clock sampling front end
`timescale 1ns/1ps
`include "isr_cfg.svh"

module isr_slave #(
  parameter int        LINK_NS   = `ISR_LINK_NS,
  parameter logic [7:0] LAST_ADDR = `ISR_LAST_ADDR,
  parameter logic [7:0] NOINC_LO  = `ISR_NOINC_LO,
  parameter logic [7:0] NOINC_HI  = `ISR_NOINC_HI
) (
  // Register side clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Link sampling clock
  input  wire logic             link_clk,
  // Pins and straps
  input  wire logic             if_sel_spi,
  input  wire logic             bus_address_select,
  input  wire logic             i2c_scl,
  input  wire logic             i2c_sda_in,
  output logic                  i2c_sda_out,
  output logic                  i2c_sda_oe,
  input  wire logic             spi_csn,
  input  wire logic             spi_sclk,
  input  wire logic             spi_mosi,
  output logic                  spi_miso,
  output logic                  spi_miso_oe,
  // Serial port configuration
  input  wire logic             cfg_auto_inc,
  input  wire logic             cfg_mode_set,
  input  wire isr_pkg::isr_mode_t cfg_mode,
  // Register file access
  output isr_pkg::isr_reg_s     reg_cmd,
  input  wire logic [7:0]       reg_rdata
);
  import isr_pkg::*;

  localparam int FILT = (`ISR_GLITCH_NS + LINK_NS - 1) / LINK_NS;

  //--------------------------------------------------------------
  // Pin synchronisers and glitch filters
  //--------------------------------------------------------------
  logic [4:0] raw;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] flt_r;
  logic [4:0] flt_nxt;
  logic [4:0] fd_r;
  logic [5:0] lv_raw;
  logic [5:0] lv1_r;
  logic [5:0] lv_r;

  assign raw    = {i2c_scl, i2c_sda_in, spi_sclk, spi_csn, spi_mosi};
  assign lv_raw = {if_sel_spi, bus_address_select, cfg_auto_inc,
                   cfg_mode_set, cfg_mode};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_flt
      logic [3:0] cnt_r;
      logic [3:0] cnt_nxt;
      always_comb begin
        flt_nxt[g] = flt_r[g];
        cnt_nxt    = 4'h0;
        if (s2_r[g] != flt_r[g]) begin
          if (cnt_r == 4'(FILT)) begin // R15
            flt_nxt[g] = s2_r[g];
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r  <= 5'h1f;
      s2_r  <= 5'h1f;
      flt_r <= 5'h1f;
      fd_r  <= 5'h1f;
      lv1_r <= 6'h00;
      lv_r  <= 6'h00;
    end else begin
      s1_r  <= raw;
      s2_r  <= s1_r;
      flt_r <= flt_nxt;
      fd_r  <= flt_r;
      lv1_r <= lv_raw;
      lv_r  <= lv1_r;
    end
  end

  logic scl;
  logic sda;
  logic sclk;
  logic csn;
  logic mosi;
  logic scl_rise;
  logic scl_fall;
  logic sda_fall;
  logic sda_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  assign {scl, sda, sclk, csn, mosi} = flt_r;
  assign scl_rise  = scl & ~fd_r[4];
  assign scl_fall  = ~scl & fd_r[4];
  assign sda_fall  = ~sda & fd_r[3] & scl & fd_r[4];
  assign sda_rise  = sda & ~fd_r[3] & scl & fd_r[4];
  assign sclk_rise = sclk & ~fd_r[2];
  assign sclk_fall = ~sclk & fd_r[2];
  assign cs_fall   = ~csn & fd_r[1];
  assign cs_rise   = csn & ~fd_r[1];

  //--------------------------------------------------------------
  // Link-side protocol engines
  //--------------------------------------------------------------
  isr_i2c_e   i_st_r, i_st_nxt;
  isr_spi_e   p_st_r, p_st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic       inc_r, inc_nxt;
  logic       rw_r, rw_nxt;
  logic       oe_r, oe_nxt;
  logic       miso_r, miso_nxt;
  logic       arm_r, arm_nxt;
  logic [7:0] armd_r, armd_nxt;
  isr_mode_t  mode_r, mode_nxt;
  logic [1:0] strap_r, strap_nxt;
  logic       need_rd_r, need_rd_nxt;
  logic       wrp_r, wrp_nxt;
  isr_req_s   wrq_r, wrq_nxt;
  isr_req_s   req_r, req_nxt;
  logic       busy_r, busy_nxt;
  logic       rtgl_r, rtgl_nxt;
  logic [7:0] rdb_r, rdb_nxt;
  logic       a1_r;
  logic       a2_r;
  logic       ad_r;
  logic       ack_tgl_r;
  logic [7:0] rsp_r;

  logic       use_spi;
  logic [7:0] dev_addr;
  logic [7:0] i_byte;
  logic [7:0] p_byte;
  logic [7:0] addr_inc;
  logic       cap;
  logic       lau;

  assign use_spi  = lv_r[5];
  assign dev_addr = lv_r[4] ? `ISR_I2C_DEV1 : `ISR_I2C_DEV0; // R19
  assign i_byte   = {sh_r[6:0], sda};
  assign p_byte   = {sh_r[6:0], mosi};
  assign addr_inc = (addr_r == LAST_ADDR) ? `ISR_ADDR_RST
                                          : addr_r + 8'h01; // R3 R7
  assign cap      = (mode_r[1] == mode_r[0]) ? sclk_rise : sclk_fall;
  assign lau      = (mode_r[1] == mode_r[0]) ? sclk_fall : sclk_rise;

  always_comb begin
    i_st_nxt    = i_st_r;
    p_st_nxt    = p_st_r;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    tx_nxt      = tx_r;
    addr_nxt    = addr_r;
    inc_nxt     = inc_r;
    rw_nxt      = rw_r;
    oe_nxt      = oe_r;
    miso_nxt    = miso_r;
    arm_nxt     = arm_r;
    armd_nxt    = armd_r;
    mode_nxt    = mode_r;
    strap_nxt   = strap_r;
    need_rd_nxt = need_rd_r;
    wrp_nxt     = wrp_r;
    wrq_nxt     = wrq_r;
    req_nxt     = req_r;
    busy_nxt    = busy_r;
    rtgl_nxt    = rtgl_r;
    rdb_nxt     = rdb_r;
    // Strap capture once synchronisers have settled
    if (strap_r != `ISR_STRAP_DLY) begin
      strap_nxt = strap_r + 2'h1;
      if (strap_r == `ISR_STRAP_DLY - 2'h1) begin
        // Straps read straight from the synchroniser, filter not yet settled
        mode_nxt = {~s2_r[3], lv_r[4]}; // R16
      end
    end
    // Answer from register side
    if (a2_r != ad_r) begin
      busy_nxt = 1'b0;
      if (!req_r.we) begin
        rdb_nxt = rsp_r;
      end
    end
    // One request in flight; writes before reads
    if (!busy_r) begin
      if (wrp_r) begin
        req_nxt  = wrq_r;
        wrp_nxt  = 1'b0;
        busy_nxt = 1'b1;
        rtgl_nxt = ~rtgl_r;
      end else if (need_rd_r) begin
        req_nxt     = '{we: 1'b0, addr: addr_r, wdata: 8'h00};
        need_rd_nxt = 1'b0;
        busy_nxt    = 1'b1;
        rtgl_nxt    = ~rtgl_r;
      end
    end
    if (!use_spi) begin
      if (sda_fall) begin
        i_st_nxt = I2C_DEV;
        bit_nxt  = 4'h0;
        oe_nxt   = 1'b0;
      end else if (sda_rise) begin
        i_st_nxt = I2C_IDLE;
        oe_nxt   = 1'b0;
      end else begin
        case (i_st_r)
          I2C_IDLE: begin
            oe_nxt = 1'b0;
          end
          I2C_DEV, I2C_REG, I2C_WR: begin
            if (scl_rise) begin
              sh_nxt  = i_byte;
              bit_nxt = bit_r + 4'h1;
            end else if (scl_fall && bit_r == `ISR_BYTE_BITS) begin
              oe_nxt   = 1'b1;
              i_st_nxt = I2C_ACK;
              if (i_st_r == I2C_DEV) begin
                if (sh_r[7:1] == dev_addr[7:1]) begin // R19
                  rw_nxt   = sh_r[0];
                  i_st_nxt = I2C_DACK;
                end else begin
                  oe_nxt   = 1'b0;
                  i_st_nxt = I2C_IDLE;
                end
              end else if (i_st_r == I2C_REG) begin
                addr_nxt    = sh_r; // R1
                inc_nxt     = (sh_r < NOINC_LO) || (sh_r > NOINC_HI);
                need_rd_nxt = 1'b1;
              end else begin
                wrp_nxt     = 1'b1; // R6
                wrq_nxt     = '{we: 1'b1, addr: addr_r, wdata: sh_r};
                addr_nxt    = inc_r ? addr_inc : addr_r; // R7
                need_rd_nxt = 1'b1;
              end
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              oe_nxt   = 1'b0;
              bit_nxt  = 4'h0;
              i_st_nxt = I2C_WR;
            end
          end
          I2C_DACK, I2C_MACK: begin
            if (scl_rise && i_st_r == I2C_MACK && sda) begin
              i_st_nxt = I2C_IDLE; // R5 R2
            end else if (scl_fall) begin
              bit_nxt = 4'h0;
              if (rw_r) begin
                tx_nxt      = {rdb_r[6:0], 1'b0}; // R1
                oe_nxt      = ~rdb_r[7];
                bit_nxt     = 4'h1;
                addr_nxt    = inc_r ? addr_inc : addr_r; // R3 R4
                need_rd_nxt = 1'b1;
                i_st_nxt    = I2C_RD;
              end else begin
                oe_nxt   = 1'b0;
                i_st_nxt = I2C_REG;
              end
            end
          end
          I2C_RD: begin
            if (scl_fall) begin
              if (bit_r == `ISR_BYTE_BITS) begin
                oe_nxt   = 1'b0;
                i_st_nxt = I2C_MACK;
              end else begin
                oe_nxt  = ~tx_r[7];
                tx_nxt  = {tx_r[6:0], 1'b0};
                bit_nxt = bit_r + 4'h1;
              end
            end
          end
          default: begin
            i_st_nxt = I2C_IDLE;
          end
        endcase
      end
    end else begin
      if (cs_rise) begin
        p_st_nxt = SPI_IDLE;
        arm_nxt  = 1'b0; // R14
      end else if (cs_fall) begin
        p_st_nxt = SPI_CMD; // R8
        bit_nxt  = 4'h0;
        miso_nxt = 1'b0;
        arm_nxt  = 1'b0;
        if (lv_r[2]) begin
          mode_nxt = lv_r[1:0]; // R17
        end
      end else begin
        case (p_st_r)
          SPI_IDLE: begin
            miso_nxt = 1'b0;
          end
          SPI_CMD: begin
            if (cap) begin
              sh_nxt  = p_byte;
              bit_nxt = bit_r + 4'h1;
              if (bit_r == `ISR_BYTE_BITS - 4'h1) begin
                bit_nxt     = 4'h0;
                rw_nxt      = p_byte[7]; // R8
                addr_nxt    = {1'b0, p_byte[6:0]}; // R9
                need_rd_nxt = p_byte[7];
                p_st_nxt    = p_byte[7] ? SPI_RD : SPI_WR;
              end
            end
          end
          SPI_RD: begin
            if (cap) begin
              sh_nxt  = p_byte;
              bit_nxt = bit_r + 4'h1;
              if (bit_r == `ISR_BYTE_BITS - 4'h1) begin
                bit_nxt     = 4'h0;
                need_rd_nxt = 1'b1;
                if (p_byte == 8'h00) begin
                  p_st_nxt = SPI_END; // R12
                end else if (lv_r[3]) begin
                  addr_nxt = addr_inc; // R11 R18
                end else begin
                  addr_nxt = {1'b0, p_byte[6:0]}; // R11
                end
              end
            end else if (lau) begin
              if (bit_r == 4'h0) begin
                miso_nxt = rdb_r[7]; // R10
                tx_nxt   = {rdb_r[6:0], 1'b0};
              end else begin
                miso_nxt = tx_r[7];
                tx_nxt   = {tx_r[6:0], 1'b0};
              end
            end
          end
          SPI_WR: begin
            if (cap) begin
              sh_nxt  = p_byte;
              bit_nxt = bit_r + 4'h1;
              if (bit_r == `ISR_BYTE_BITS - 4'h1) begin
                bit_nxt  = 4'h0;
                arm_nxt  = 1'b1;
                armd_nxt = p_byte;
              end
            end else if (lau) begin
              miso_nxt = sh_r[7]; // R18
              if (arm_r) begin
                arm_nxt  = 1'b0; // R14
                wrp_nxt  = 1'b1; // R13
                wrq_nxt  = '{we: 1'b1, addr: addr_r, wdata: armd_r};
                addr_nxt = lv_r[3] ? addr_inc : addr_r; // R13
              end
            end
          end
          SPI_END: begin
            if (lau) begin
              miso_nxt = tx_r[7];
              tx_nxt   = {tx_r[6:0], 1'b0};
            end
          end
          default: begin
            p_st_nxt = SPI_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      i_st_r    <= I2C_IDLE;
      p_st_r    <= SPI_IDLE;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      addr_r    <= `ISR_ADDR_RST;
      inc_r     <= 1'b1;
      rw_r      <= 1'b0;
      oe_r      <= 1'b0;
      miso_r    <= 1'b0;
      arm_r     <= 1'b0;
      armd_r    <= 8'h00;
      mode_r    <= `ISR_MODE_RST;
      strap_r   <= 2'h0;
      need_rd_r <= 1'b0;
      wrp_r     <= 1'b0;
      wrq_r     <= '0;
      req_r     <= '0;
      busy_r    <= 1'b0;
      rtgl_r    <= 1'b0;
      rdb_r     <= 8'h00;
      a1_r      <= 1'b0;
      a2_r      <= 1'b0;
      ad_r      <= 1'b0;
    end else begin
      i_st_r    <= i_st_nxt;
      p_st_r    <= p_st_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      tx_r      <= tx_nxt;
      addr_r    <= addr_nxt;
      inc_r     <= inc_nxt;
      rw_r      <= rw_nxt;
      oe_r      <= oe_nxt;
      miso_r    <= miso_nxt;
      arm_r     <= arm_nxt;
      armd_r    <= armd_nxt;
      mode_r    <= mode_nxt;
      strap_r   <= strap_nxt;
      need_rd_r <= need_rd_nxt;
      wrp_r     <= wrp_nxt;
      wrq_r     <= wrq_nxt;
      req_r     <= req_nxt;
      busy_r    <= busy_nxt;
      rtgl_r    <= rtgl_nxt;
      rdb_r     <= rdb_nxt;
      a1_r      <= ack_tgl_r;
      a2_r      <= a1_r;
      ad_r      <= a2_r;
    end
  end

  // Open drain: only ever pulls low
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe  = oe_r;
  assign spi_miso    = miso_r;
  assign spi_miso_oe = use_spi & ~csn; // R20

  //--------------------------------------------------------------
  // Register-side end of the request handshake
  //--------------------------------------------------------------
  logic     q1_r;
  logic     q2_r;
  logic     qd_r;
  logic     ack_nxt;
  logic [7:0] rsp_nxt;
  isr_reg_s cmd_r, cmd_nxt;

  always_comb begin
    cmd_nxt    = '{wr: 1'b0, rd: 1'b0, addr: cmd_r.addr,
                   wdata: cmd_r.wdata};
    ack_nxt    = ack_tgl_r;
    rsp_nxt    = rsp_r;
    if (q2_r != qd_r) begin
      cmd_nxt = '{wr: req_r.we, rd: ~req_r.we, addr: req_r.addr,
                  wdata: req_r.wdata};
    end
    if (cmd_r.wr || cmd_r.rd) begin
      ack_nxt = ~ack_tgl_r;
      if (cmd_r.rd) begin
        rsp_nxt = reg_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q1_r      <= 1'b0;
      q2_r      <= 1'b0;
      qd_r      <= 1'b0;
      cmd_r     <= '0;
      ack_tgl_r <= 1'b0;
      rsp_r     <= 8'h00;
    end else begin
      q1_r      <= rtgl_r;
      q2_r      <= q1_r;
      qd_r      <= q2_r;
      cmd_r     <= cmd_nxt;
      ack_tgl_r <= ack_nxt;
      rsp_r     <= rsp_nxt;
    end
  end

  assign reg_cmd = cmd_r;

endmodule

// File: verif/isr_host.sv
// Host model: SPI and I2C master paced by the system clock
`timescale 1ns/1ps

module isr_host (
  // Pacing clock
  input  wire logic clk,
  // SPI master
  output logic      spi_csn,
  output logic      spi_sclk,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  // I2C master, clock driven both ways, data pull-down only
  output logic      i2c_scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  localparam int HALF = 30;
  localparam int QTR  = 25;
  logic [1:0] mode_r;

  initial begin
    spi_csn = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    i2c_scl = 1'b1;
    sda_low = 1'b0;
    mode_r = 2'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic spi_begin(input logic [1:0] m);
    mode_r = m;
    spi_sclk = m[1];
    wt(HALF);
    spi_csn = 1'b0;
    wt(HALF);
  endtask

  // Leading edge launches when phase is set, else trailing edge
  task automatic spi_byte(input logic [7:0] tx, input int n,
                          output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (mode_r[0]) begin
        spi_sclk = ~spi_sclk;
      end
      spi_mosi = tx[i];
      wt(HALF);
      spi_sclk = ~spi_sclk;
      rx[i] = spi_miso;
      wt(HALF);
      if (!mode_r[0]) begin
        spi_sclk = ~spi_sclk;
      end
    end
  endtask

  task automatic spi_end();
    wt(HALF);
    spi_csn = 1'b1;
    spi_mosi = ~spi_mosi;
    wt(4 * HALF);
  endtask

  // Pulses shorter than the filter on clock and select
  task automatic glitch();
    spi_sclk = ~spi_sclk;
    #40 spi_sclk = ~spi_sclk;
    wt(5);
    spi_csn = 1'b1;
    #40 spi_csn = 1'b0;
    wt(HALF);
  endtask

  task automatic i2c_bit(input logic b, output logic r);
    sda_low = ~b;
    wt(QTR);
    i2c_scl = 1'b1;
    wt(QTR);
    r = sda_wire;
    wt(QTR);
    i2c_scl = 1'b0;
    wt(QTR);
  endtask

  task automatic i2c_start();
    sda_low = 1'b0;
    wt(QTR);
    i2c_scl = 1'b1;
    wt(2 * QTR);
    sda_low = 1'b1;
    wt(2 * QTR);
    i2c_scl = 1'b0;
    wt(QTR);
  endtask

  task automatic i2c_stop();
    sda_low = 1'b1;
    wt(QTR);
    i2c_scl = 1'b1;
    wt(2 * QTR);
    sda_low = 1'b0;
    wt(4 * QTR);
  endtask

  task automatic i2c_wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], r);
    end
    i2c_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic i2c_rbyte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, r);
      b[i] = r;
    end
    i2c_bit(~ack, r);
  endtask
endmodule

// File: verif/isr_slave_chk.sv
// Checker bound to the serial register slave
`timescale 1ns/1ps

module isr_slave_chk #(
  parameter logic [7:0] LAST_ADDR = 8'h7f
) (
  // Clocks and reset
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              link_clk,
  // Pins
  input wire logic              if_sel_spi,
  input wire logic              i2c_scl,
  input wire logic              i2c_sda_out,
  input wire logic              i2c_sda_oe,
  input wire logic              spi_csn,
  input wire logic              spi_miso_oe,
  // Register access
  input wire isr_pkg::isr_reg_s reg_cmd
);
  import isr_pkg::*;

  // --------------------------------------------------------------
  // Pin side
  // --------------------------------------------------------------
  a_miso_release: assert property (
    @(posedge link_clk) disable iff (!resetn)
    spi_csn [*8] |-> !spi_miso_oe)
    else $error("miso driven idle");
  a_sda_open_drain: assert property (
    @(posedge link_clk) disable iff (!resetn)
    i2c_sda_oe |-> !i2c_sda_out)
    else $error("sda driven high");
  a_sda_scl_low: assert property (
    @(posedge link_clk) disable iff (!resetn)
    $changed(i2c_sda_oe) |-> !i2c_scl)
    else $error("sda changed while scl high");
  a_sda_spi_quiet: assert property (
    @(posedge link_clk) disable iff (!resetn)
    if_sel_spi [*8] |-> !i2c_sda_oe)
    else $error("sda pulled in spi mode");

  // --------------------------------------------------------------
  // Register side
  // --------------------------------------------------------------
  a_wr_pulse: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_cmd.wr |=> !reg_cmd.wr && !reg_cmd.rd)
    else $error("write strobe long");
  a_rd_pulse: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_cmd.rd |-> !reg_cmd.wr ##1 !reg_cmd.rd)
    else $error("read strobe malformed");
  a_addr_range: assert property (
    @(posedge clk) disable iff (!resetn)
    (reg_cmd.wr || reg_cmd.rd) |-> reg_cmd.addr <= LAST_ADDR)
    else $error("address past wrap");
  a_cmd_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !reg_cmd.wr && !reg_cmd.rd |-> $stable(reg_cmd.addr))
    else $error("address moved idle");

  c_write: cover property (@(posedge clk) reg_cmd.wr);
  c_read: cover property (@(posedge clk) reg_cmd.rd);
  c_ack: cover property (@(posedge link_clk) $rose(i2c_sda_oe));
endmodule

bind isr_slave isr_slave_chk #(.LAST_ADDR(LAST_ADDR)) u_chk (.*);

// File: verif/tb_top.sv
// Self-checking bench for the serial register slave
`timescale 1ns/1ps

module tb_top;
  import isr_pkg::*;

  logic        clk, link_clk, resetn, if_sel_spi, bus_address_select;
  logic        i2c_scl, i2c_sda_out, i2c_sda_oe, sda_low, sda_w, ack;
  logic        spi_csn, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, miso_w;
  logic        cfg_auto_inc, cfg_mode_set;
  isr_mode_t   cfg_mode;
  isr_reg_s    reg_cmd;
  logic [7:0]  reg_rdata, r;
  logic [15:0] wq[$];
  int          mismatches, check_count;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  isr_slave #(.NOINC_LO(8'h40), .NOINC_HI(8'h4f)) dut (
    .*, .i2c_sda_in(sda_w));

  isr_host host (.*, .spi_miso(miso_w), .sda_wire(sda_w));

  // ------------------------------------------------------------
  // Wires and register file model
  // ------------------------------------------------------------
  assign sda_w = !(sda_low || i2c_sda_oe);
  assign miso_w = spi_miso_oe ? spi_miso : 1'bz;
  assign reg_rdata = reg_cmd.addr ^ 8'h5a;
  always @(posedge clk)
    if (reg_cmd.wr === 1'b1) wq.push_back({reg_cmd.addr, reg_cmd.wdata});

  function automatic logic [15:0] rd_val(input logic [7:0] a);
    return 16'(a ^ 8'h5a);
  endfunction

  task automatic check(input string what, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_wr(input int n, input logic [15:0] e0, e1);
    check("write count", 16'(wq.size()), 16'(n));
    if (n > 0) check("first write", wq[0], e0);
    if (n > 1) check("second write", wq[1], e1);
    wq.delete();
  endtask

  task automatic do_rst(input logic low_sda, input logic sel);
    resetn = 1'b0;
    host.sda_low = low_sda;
    bus_address_select = sel;
    host.wt(3);
    resetn = 1'b1;
    host.wt(20);
    host.sda_low = 1'b0;
    bus_address_select = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_spi_write();
    logic [7:0] d1;
    cfg_auto_inc = 1'b1;
    host.spi_begin(2'h0);
    host.spi_byte(8'h05, 8, r);
    host.spi_byte(8'haa, 8, r);
    host.glitch();
    host.spi_byte(8'hbb, 8, d1);
    host.spi_end();
    check("daisy first", 16'(r), 16'h0005);
    check("daisy second", 16'(d1), 16'h00aa);
    chk_wr(2, 16'h05aa, 16'h06bb);
    cfg_auto_inc = 1'b0;
    host.spi_begin(2'h0);
    host.spi_byte(8'h20, 8, r);
    host.spi_byte(8'h11, 8, r);
    host.spi_byte(8'h22, 8, r);
    host.spi_end();
    chk_wr(2, 16'h2011, 16'h2022);
    $display("test spi_write done");
  endtask

  task automatic t_spi_read();
    cfg_auto_inc = 1'b1;
    host.spi_begin(2'h0);
    host.spi_byte(8'hfe, 8, r);
    host.spi_byte(8'hff, 8, r);
    check("read first", 16'(r), rd_val(8'h7e));
    host.spi_byte(8'hff, 8, r);
    check("read next", 16'(r), rd_val(8'h7f));
    host.spi_byte(8'h00, 8, r);
    check("read wrap", 16'(r), rd_val(8'h00));
    host.spi_end();
    cfg_auto_inc = 1'b0;
    host.spi_begin(2'h0);
    host.spi_byte(8'h90, 8, r);
    host.spi_byte(8'h12, 8, r);
    check("read fixed", 16'(r), rd_val(8'h10));
    host.spi_byte(8'h00, 8, r);
    check("read chosen", 16'(r), rd_val(8'h12));
    host.spi_end();
    $display("test spi_read done");
  endtask

  task automatic t_spi_abort();
    cfg_auto_inc = 1'b1;
    host.spi_begin(2'h0);
    host.spi_byte(8'h0a, 8, r);
    host.spi_byte(8'h77, 5, r);
    host.spi_end();
    chk_wr(0, 16'h0000, 16'h0000);
    $display("test spi_abort done");
  endtask

  task automatic t_spi_modes();
    cfg_auto_inc = 1'b0;
    do_rst(1'b1, 1'b1);
    for (int m = 3; m >= 0; m--) begin
      cfg_mode_set = (m != 3);
      cfg_mode = 2'(m);
      host.spi_begin(2'(m));
      host.spi_byte(8'(8'h30 + m), 8, r);
      host.spi_byte(8'(8'hc0 + m), 8, r);
      host.spi_byte(8'(8'hc0 + m), 8, r);
      host.spi_end();
      check("mode write", wq[$], 16'(16'h30c0 + 16'h0101 * m));
      wq.delete();
    end
    $display("test spi_modes done");
  endtask

  task automatic i2c_w(input logic [7:0] b);
    host.i2c_wbyte(b, ack);
    check("i2c ack", 16'(ack), 16'h0001);
  endtask

  task automatic t_i2c();
    if_sel_spi = 1'b0;
    host.wt(20);
    host.i2c_start();
    i2c_w(8'h82);
    i2c_w(8'h7f);
    i2c_w(8'h31);
    i2c_w(8'h32);
    host.i2c_stop();
    chk_wr(2, 16'h7f31, 16'h0032);
    host.i2c_start();
    host.i2c_wbyte(8'h88, ack);
    check("foreign address", 16'(ack), 16'h0000);
    host.i2c_stop();
    host.i2c_start();
    i2c_w(8'h82);
    i2c_w(8'h7e);
    host.i2c_start();
    i2c_w(8'h83);
    host.i2c_rbyte(1'b1, r);
    check("i2c read", 16'(r), rd_val(8'h7e));
    host.i2c_rbyte(1'b1, r);
    check("i2c next", 16'(r), rd_val(8'h7f));
    host.i2c_rbyte(1'b0, r);
    check("i2c wrap", 16'(r), rd_val(8'h00));
    check("sda after nack", 16'(sda_w), 16'h0001);
    host.i2c_stop();
    host.i2c_start();
    i2c_w(8'h82);
    i2c_w(8'h40);
    host.i2c_start();
    i2c_w(8'h83);
    host.i2c_rbyte(1'b1, r);
    check("fixed first", 16'(r), rd_val(8'h40));
    host.i2c_rbyte(1'b0, r);
    check("fixed second", 16'(r), rd_val(8'h40));
    host.i2c_stop();
    $display("test i2c done");
  endtask

  initial begin
    resetn = 1'b0;
    if_sel_spi = 1'b1;
    bus_address_select = 1'b0;
    cfg_auto_inc = 1'b0;
    cfg_mode_set = 1'b0;
    cfg_mode = 2'h0;
    mismatches = 0;
    check_count = 0;
    do_rst(1'b0, 1'b0);
    t_spi_write();
    t_spi_read();
    t_spi_abort();
    t_spi_modes();
    t_i2c();
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule
